// file: ppo_pkg.sv
// package for the packet ordering and priority port: constants, packet carrier, states
package ppo_pkg;

	// ==========================================================================
	// priority scale and packet classes
	localparam int          PRIO_LEVELS  = 4;
	localparam logic [1:0]  PRIO_TOP     = 2'h3;
	localparam logic [1:0]  PRIO_LOW     = 2'h0;
	localparam logic [3:0]  FTYPE_MAINT  = 4'h8;

	// ==========================================================================
	// buffer sizing
	localparam int          TXQ_DEPTH    = 4;
	localparam int          RXQ_DEPTH    = 16;
	localparam int          RX_RSV_LEVEL = 1;
	localparam int          MIN_RX_SLOTS = 4;
	localparam int          NUM_OUT_PORT = 4;

	// ==========================================================================
	// field widths
	localparam int          ID_W         = 8;
	localparam int          PAYLOAD_W    = 32;

	// ==========================================================================
	// packet carrier; one word stands for one maximum-length packet
	typedef struct packed {
		logic [1:0]           prio;
		logic                 crf;
		logic [3:0]           ftype;
		logic                 isResp;
		logic                 needResp;
		logic [ID_W-1:0]      srcEndpointId;
		logic [ID_W-1:0]      destEndpointId;
		logic [PAYLOAD_W-1:0] payload;
	} ppo_pkt_t;

	localparam int          PKT_W        = $bits(ppo_pkt_t);

	// ==========================================================================
	// transmit state
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_WAIT = 1'b1
	} ppo_tx_state_t;

endpackage

// file: ppo_port.sv
// packet ordering, priority selection and input reservation for one fabric port
`timescale 1ns/1ps

// ============================================================================
// receive buffer: plain fifo with valid/ready on both sides and a fill level
module ppo_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	input  wire logic                       inValid,
	output logic                            inReady,
	input  wire logic [WIDTH-1:0]           inData,
	output logic                            outValid,
	input  wire logic                       outReady,
	output logic [WIDTH-1:0]                outData,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [CW-1:0]               count;
	} ppo_fifo_state_t;

	ppo_fifo_state_t st_ff;
	ppo_fifo_state_t nxt_st;
	logic            doWr;
	logic            doRd;

	assign inReady  = st_ff.count != FULL_CNT;
	assign outValid = st_ff.count != '0;
	assign outData  = st_ff.mem[st_ff.rdPtr];
	assign level    = st_ff.count;
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	always_comb begin
		nxt_st = st_ff;
		if (doWr) begin
			nxt_st.mem[st_ff.wrPtr] = inData;
			nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH-1)) ? '0 : st_ff.wrPtr + 1'b1;
		end
		if (doRd) begin
			nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH-1)) ? '0 : st_ff.rdPtr + 1'b1;
		end
		if (doWr && !doRd) begin
			nxt_st.count = st_ff.count + 1'b1;
		end else if (doRd && !doWr) begin
			nxt_st.count = st_ff.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// ============================================================================
// Notes on behaviour
// - packets of one request flow leave in the order the transport gave them
// - an earlier higher priority request leaves before a later lower one
// - received packets reach the transport in link arrival order
// - a sent packet stays queued and owned here until the partner accepts it
// - in switch role, priority and critical flow bit pass unchanged
// - switch output port is picked from the destination id alone
// - switch keeps order within source, destination, priority and flow
// - lower priority never overtakes higher priority between same endpoints
// - maintenance packet never passes one of equal or higher priority
// - a response goes out at least one level above its request
// - a request expecting a response never uses the top level
// - switch accepts priority N when no older N-or-higher packet waits
// - one maximum-length input slot is reserved per level, usable by higher
// - after a retry at N, a queued packet above N goes next
// - endpoint accepts when its space for level N fits; else only retry
// - accept or retry depends only on input space, never on transmit state
// - requests never fill a transmit queue; a slot stays for responses
// - responses can leave while requests are blocked
// - at least four input slots with per-level reservation plus upward pick
// - a retried response is raised one level per retry, no further
// - four levels, 0 lowest and 3 highest
module ppo_port
	import ppo_pkg::*;
#(
	parameter int TXQ_D    = ppo_pkg::TXQ_DEPTH,
	parameter int RXQ_D    = ppo_pkg::RXQ_DEPTH,
	parameter int OUT_PORT = ppo_pkg::NUM_OUT_PORT
) (
	input  wire logic                           clk_sys,
	input  wire logic                           reset,
	input  wire logic                           switchMode,
	input  wire logic                           tpTxValid,
	output logic                                tpTxReady,
	input  wire ppo_pkg::ppo_pkt_t              tpTxPkt,
	output logic                                lnkTxValid,
	output ppo_pkg::ppo_pkt_t                   lnkTxPkt,
	output logic [$clog2(OUT_PORT)-1:0]         lnkTxOutPort,
	input  wire logic                           lnkTxAccepted,
	input  wire logic                           lnkTxRetry,
	input  wire logic                           lnkRxValid,
	input  wire ppo_pkg::ppo_pkt_t              lnkRxPkt,
	output logic                                lnkRxAccept,
	output logic                                lnkRxRetry,
	output logic                                tpRxValid,
	input  wire logic                           tpRxReady,
	output ppo_pkg::ppo_pkt_t                   tpRxPkt
);
	import ppo_pkg::*;

	localparam int QCW = $clog2(TXQ_D+1);
	localparam int RCW = $clog2(RXQ_D+1);
	localparam int OPW = $clog2(OUT_PORT);
	localparam logic [QCW-1:0] Q_FULL    = QCW'(TXQ_D);
	localparam logic [QCW-1:0] Q_REQ_MAX = QCW'(TXQ_D-1);
	localparam logic [RCW-1:0] RX_SLOTS  = RCW'(RXQ_D);
	localparam logic [RCW-1:0] RX_RSV    = RCW'(RX_RSV_LEVEL);

	// ========================================================================
	// state
	typedef struct packed {
		logic [PRIO_LEVELS-1:0][TXQ_D-1:0][PKT_W-1:0] qMem;
		logic [PRIO_LEVELS-1:0][QCW-1:0]              qCnt;
		logic [PRIO_LEVELS-1:0][1:0]                  qPromo;
		ppo_tx_state_t                                txState;
		logic [1:0]                                   txQ;
		ppo_pkt_t                                     txPkt;
		logic [OPW-1:0]                               outPort;
	} ppo_state_t;

	ppo_state_t     st_ff;
	ppo_state_t     nxt_st;
	ppo_pkt_t       enqPkt;
	logic [1:0]     enqQ;
	logic           enqOk;
	logic           doPop;
	logic           doRetry;
	logic [RCW-1:0] rxLevel;
	logic [RCW-1:0] rxFree;
	logic [RCW-1:0] rxNeed;
	logic           rxFits;
	logic           rxInReady;

	// ========================================================================
	// enqueue: priority assignment and response room
	always_comb begin
		enqPkt = tpTxPkt;
		if (!switchMode && tpTxPkt.isResp && tpTxPkt.prio != PRIO_TOP) begin
			enqPkt.prio = tpTxPkt.prio + 2'h1;
		end
		if (!switchMode && tpTxPkt.needResp && !tpTxPkt.isResp &&
			tpTxPkt.prio == PRIO_TOP) begin
			enqPkt.prio = PRIO_TOP - 2'h1;
		end
	end

	assign enqQ = enqPkt.prio;
	// requests stop one short of full so one slot per level stays for a response
	assign enqOk = enqPkt.isResp ? (st_ff.qCnt[enqQ] != Q_FULL)
		: (st_ff.qCnt[enqQ] < Q_REQ_MAX);
	assign tpTxReady = enqOk;

	assign doPop   = st_ff.txState == TX_WAIT && lnkTxAccepted;
	assign doRetry = st_ff.txState == TX_WAIT && lnkTxRetry && !lnkTxAccepted;

	// ========================================================================
	// queues, selection and promotion
	always_comb begin
		logic [QCW-1:0] wrIdx;
		logic [1:0]     sel;
		logic           found;
		logic [2:0]     effSum;
		ppo_pkt_t       head;
		wrIdx  = '0;
		sel    = '0;
		found  = 1'b0;
		effSum = '0;
		head   = '0;
		nxt_st = st_ff;

		// accepted head leaves; the rest of the level keeps its age order
		if (doPop) begin
			for (int i = 0; i < TXQ_D-1; i++) begin
				nxt_st.qMem[st_ff.txQ][i] = st_ff.qMem[st_ff.txQ][i+1];
			end
			nxt_st.qCnt[st_ff.txQ]   = st_ff.qCnt[st_ff.txQ] - 1'b1;
			nxt_st.qPromo[st_ff.txQ] = 2'h0;
			nxt_st.txState           = TX_IDLE;
		end
		if (doRetry) begin
			nxt_st.txState = TX_IDLE;
			// responses climb one level per retry, only as far as the top level
			if (!switchMode && st_ff.txPkt.isResp && st_ff.txPkt.prio != PRIO_TOP) begin
				nxt_st.qPromo[st_ff.txQ] = st_ff.qPromo[st_ff.txQ] + 2'h1;
			end
		end

		if (tpTxValid && enqOk) begin
			wrIdx = st_ff.qCnt[enqQ];
			if (doPop && st_ff.txQ == enqQ) begin
				wrIdx = st_ff.qCnt[enqQ] - 1'b1;
			end
			nxt_st.qMem[enqQ][wrIdx[$clog2(TXQ_D)-1:0]] = enqPkt;
			nxt_st.qCnt[enqQ] = nxt_st.qCnt[enqQ] + 1'b1;
		end

		// highest non-empty level wins, so a retry at N yields to anything above
		for (int p = 0; p < PRIO_LEVELS; p++) begin
			if (st_ff.qCnt[p] != '0) begin
				sel   = 2'(p);
				found = 1'b1;
			end
		end
		if (st_ff.txState == TX_IDLE && found) begin
			head   = ppo_pkt_t'(st_ff.qMem[sel][0]);
			effSum = {1'b0, head.prio} + {1'b0, st_ff.qPromo[sel]};
			if (!switchMode) begin
				head.prio = (effSum > {1'b0, PRIO_TOP}) ? PRIO_TOP : effSum[1:0];
			end
			nxt_st.txPkt   = head;
			nxt_st.txQ     = sel;
			nxt_st.outPort = head.destEndpointId[OPW-1:0];
			nxt_st.txState = TX_WAIT;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lnkTxValid   = st_ff.txState == TX_WAIT;
	assign lnkTxPkt     = st_ff.txPkt;
	assign lnkTxOutPort = st_ff.outPort;

	// ========================================================================
	// receive: reservation of one slot per level above the arriving one
	assign rxFree = RX_SLOTS - rxLevel;
	assign rxNeed = RCW'(PRIO_TOP - lnkRxPkt.prio) * RX_RSV;
	// only free space decides; transmit congestion is deliberately not looked at
	assign rxFits      = rxFree > rxNeed && rxInReady;
	assign lnkRxAccept = lnkRxValid && rxFits;
	assign lnkRxRetry  = lnkRxValid && !rxFits;

	ppo_fifo #(
		.WIDTH (PKT_W),
		.DEPTH (RXQ_D)
	) rxBuf (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.inValid  (lnkRxAccept),
		.inReady  (rxInReady),
		.inData   (lnkRxPkt),
		.outValid (tpRxValid),
		.outReady (tpRxReady),
		.outData  (tpRxPkt),
		.level    (rxLevel)
	);

	// ========================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_TX_HELD: assert property (
		lnkTxValid && !lnkTxAccepted && !lnkTxRetry |=> lnkTxValid && $stable(lnkTxPkt))
		else $error("in-flight packet dropped or changed before acceptance");
	AST_RESP_UP: assert property (
		tpTxValid && tpTxReady && !switchMode && tpTxPkt.isResp && tpTxPkt.prio != PRIO_TOP
		|=> st_ff.qCnt[$past(tpTxPkt.prio) + 2'h1] != '0)
		else $error("response not queued above its request level");
	AST_NO_TOP_REQ: assert property (
		lnkTxValid && !switchMode && lnkTxPkt.needResp && !lnkTxPkt.isResp
		|-> lnkTxPkt.prio != PRIO_TOP)
		else $error("request expecting response sent at top level");
	AST_SW_PRIO: assert property (
		switchMode && $rose(lnkTxValid) |-> lnkTxPkt.prio == st_ff.txQ)
		else $error("switch altered packet priority");
	AST_ROUTE: assert property (
		lnkTxValid |-> lnkTxOutPort == lnkTxPkt.destEndpointId[OPW-1:0])
		else $error("output port not taken from destination id");
	AST_TOP_FIRST: assert property (
		st_ff.txState == TX_IDLE && st_ff.qCnt[3] != '0 |=> lnkTxValid && st_ff.txQ == 2'h3)
		else $error("higher level bypassed in selection");
	AST_RX_TOP: assert property (
		lnkRxValid && lnkRxPkt.prio == PRIO_TOP && rxLevel < RX_SLOTS |-> lnkRxAccept)
		else $error("top level packet retried with space free");
	AST_RX_RSV: assert property (
		lnkRxValid && lnkRxPkt.prio == PRIO_LOW && rxLevel >= RX_SLOTS - RCW'(3) |-> lnkRxRetry)
		else $error("reserved slot given to lowest level");
	AST_REQ_ROOM: assert property (
		tpTxValid && tpTxReady && !enqPkt.isResp |=> st_ff.qCnt[$past(enqQ)] < Q_FULL)
		else $error("requests filled a transmit queue");
	AST_RESP_OK: assert property (
		tpTxValid && enqPkt.isResp && st_ff.qCnt[enqQ] < Q_REQ_MAX |-> tpTxReady)
		else $error("response refused while room is held back");
	AST_RX_ORDER: assert property (
		tpRxValid && !tpRxReady |=> tpRxValid && $stable(tpRxPkt))
		else $error("receive head changed while stalled");

	COV_RETRY: cover property (lnkTxValid && lnkTxRetry ##1 !lnkTxValid ##1 lnkTxValid);
	COV_PROMO: cover property (st_ff.qPromo[1] != 2'h0);
	COV_RX_RETRY: cover property (lnkRxRetry);
	COV_RX_FULL: cover property (!rxInReady ##1 tpRxValid && tpRxReady);
endmodule

// file: ppo_link_partner.sv
// link partner model: accepts or retries each offered packet after a programmable hold
`timescale 1ns/1ps

// ============================================================================
// far side of the transmit link
module ppo_link_partner (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              lnkTxValid,
	input  wire ppo_pkg::ppo_pkt_t lnkTxPkt,
	input  wire logic [1:0]        lnkTxOutPort,
	output logic                   lnkTxAccepted,
	output logic                   lnkTxRetry
);
	import ppo_pkg::*;

	int         holdCycles = 0;
	int         retryLeft  = 0;
	int         waitCnt    = 0;
	ppo_pkt_t   gotQ[$];
	logic [1:0] portQ[$];

	initial begin
		lnkTxAccepted = 1'b0;
		lnkTxRetry    = 1'b0;
	end

	// one answer per standing offer; the pulse guard stops a second answer to the same offer
	always @(posedge clk_sys) begin
		lnkTxAccepted <= 1'b0;
		lnkTxRetry    <= 1'b0;
		if (reset) begin
			waitCnt <= 0;
		end else if (lnkTxValid && !lnkTxAccepted && !lnkTxRetry) begin
			if (waitCnt < holdCycles) begin
				waitCnt <= waitCnt + 1;
			end else if (retryLeft > 0) begin
				waitCnt    <= 0;
				retryLeft  <= retryLeft - 1;
				lnkTxRetry <= 1'b1;
			end else begin
				waitCnt       <= 0;
				lnkTxAccepted <= 1'b1;
				gotQ.push_back(lnkTxPkt);
				portQ.push_back(lnkTxOutPort);
			end
		end
	end
endmodule

// file: testbench.sv
// self-checking testbench for the packet ordering port
`timescale 1ns/1ps

module testbench;
	import ppo_pkg::*;

	logic       clk_sys, reset, switchMode, tpTxValid, tpTxReady, lnkTxValid;
	logic       lnkTxAccepted, lnkTxRetry, lnkRxValid, lnkRxAccept, lnkRxRetry;
	logic       tpRxValid, tpRxReady;
	logic [1:0] lnkTxOutPort;
	ppo_pkt_t   tpTxPkt, lnkTxPkt, lnkRxPkt, tpRxPkt;
	int         failures = 0;
	int         compares = 0;

	ppo_port u_dut (.clk_sys(clk_sys), .reset(reset), .switchMode(switchMode),
		.tpTxValid(tpTxValid), .tpTxReady(tpTxReady), .tpTxPkt(tpTxPkt),
		.lnkTxValid(lnkTxValid), .lnkTxPkt(lnkTxPkt), .lnkTxOutPort(lnkTxOutPort),
		.lnkTxAccepted(lnkTxAccepted), .lnkTxRetry(lnkTxRetry), .lnkRxValid(lnkRxValid),
		.lnkRxPkt(lnkRxPkt), .lnkRxAccept(lnkRxAccept), .lnkRxRetry(lnkRxRetry),
		.tpRxValid(tpRxValid), .tpRxReady(tpRxReady), .tpRxPkt(tpRxPkt));

	ppo_link_partner u_partner (.clk_sys(clk_sys), .reset(reset), .lnkTxValid(lnkTxValid),
		.lnkTxPkt(lnkTxPkt), .lnkTxOutPort(lnkTxOutPort),
		.lnkTxAccepted(lnkTxAccepted), .lnkTxRetry(lnkTxRetry));

	// ========================================================================
	// shared tasks
	task automatic check(input logic [PKT_W-1:0] seen, input logic [PKT_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// k is {isResp, needResp}; crf follows payload bit 0
	function automatic ppo_pkt_t mk(input logic [1:0] p, input logic [1:0] k,
		input logic [3:0] ft, input logic [7:0] d, input logic [31:0] pay);
		mk = '{prio: p, crf: pay[0], ftype: ft, isResp: k[1], needResp: k[0],
			srcEndpointId: 8'h11, destEndpointId: d, payload: pay};
	endfunction

	task automatic do_reset();
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
	endtask

	// a refused offer is withdrawn, so it never reaches the queue
	task automatic offer(input ppo_pkt_t p, input logic expReady);
		@(posedge clk_sys);
		tpTxValid <= 1'b1;
		tpTxPkt   <= p;
		@(negedge clk_sys);
		check(tpTxReady, expReady);
		@(posedge clk_sys);
		tpTxValid <= 1'b0;
	endtask

	task automatic expect_got(input ppo_pkt_t e[$]);
		int n = 0;
		while (u_partner.gotQ.size() < e.size() && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		check(u_partner.gotQ.size(), e.size());
		foreach (e[i]) begin
			if (i < u_partner.gotQ.size()) begin
				check(u_partner.gotQ[i], e[i]);
				check(u_partner.portQ[i], e[i].destEndpointId[1:0]);
			end
		end
		u_partner.gotQ.delete();
		u_partner.portQ.delete();
	endtask

	// ========================================================================
	// scenarios
	task automatic tx_order();
		ppo_pkt_t q[$];
		q = {mk(2'h0, 2'h0, 4'h2, 8'h05, 32'h2), mk(2'h0, 2'h0, 4'h2, 8'h06, 32'h4),
			mk(2'h1, 2'h0, 4'h2, 8'h07, 32'h6), mk(2'h2, 2'h0, 4'h2, 8'h0A, 32'h8)};
		u_partner.holdCycles = 20;
		foreach (q[i]) offer(q[i], 1'b1);
		expect_got({q[0], q[3], q[2], q[1]});
	endtask

	task automatic promote();
		int       tab[5][5] = '{'{1, 2, 3, 1, 0}, '{0, 2, 1, 0, 0}, '{3, 2, 3, 0, 0},
			'{3, 1, 2, 0, 0}, '{2, 1, 2, 0, 0}};
		ppo_pkt_t p;
		u_partner.holdCycles = 0;
		foreach (tab[i]) begin
			u_partner.retryLeft = tab[i][3];
			p = mk(2'(tab[i][0]), 2'(tab[i][1]), 4'hD, 8'h03, 32'(i));
			offer(p, 1'b1);
			p.prio = 2'(tab[i][2]);
			expect_got({p});
		end
	endtask

	// transport stalls while the receive buffer fills, so every slot is tested
	task automatic rx_fill();
		logic [1:0] prs[5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
		logic [1:0] pr;
		logic       fits;
		int         lvl = 0;
		ppo_pkt_t   e[$];
		ppo_pkt_t   p;
		for (int i = 0; i < 19; i++) begin
			pr = (i < 14) ? 2'h0 : prs[i-14];
			p = mk(pr, 2'h0, 4'h2, 8'h09, 32'(i));
			fits = (RXQ_DEPTH - lvl) > (int'(PRIO_TOP) - int'(pr)) * RX_RSV_LEVEL;
			fits = fits && lvl < RXQ_DEPTH;
			@(posedge clk_sys);
			lnkRxValid <= 1'b1;
			lnkRxPkt   <= p;
			@(negedge clk_sys);
			check(lnkRxAccept, fits);
			check(lnkRxRetry, !fits);
			if (fits) begin
				lvl++;
				e.push_back(p);
			end
		end
		@(posedge clk_sys);
		lnkRxValid <= 1'b0;
		tpRxReady  <= 1'b1;
		foreach (e[i]) begin
			@(negedge clk_sys);
			check(tpRxValid, 1'b1);
			check(tpRxPkt, e[i]);
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		check(tpRxValid, 1'b0);
		@(posedge clk_sys);
		tpRxReady <= 1'b0;
	endtask

	task automatic tx_full();
		ppo_pkt_t q[$];
		for (int i = 0; i < 3; i++) q.push_back(mk(2'h1, 2'h0, 4'h2, 8'h01, 32'(i)));
		q.push_back(mk(2'h0, 2'h2, 4'hD, 8'h01, 32'h7));
		u_partner.holdCycles = 200;
		foreach (q[i]) offer(q[i], 1'b1);
		offer(mk(2'h1, 2'h0, 4'h2, 8'h01, 32'h9), 1'b0);
		offer(mk(2'h0, 2'h2, 4'hD, 8'h01, 32'h8), 1'b0);
		rx_fill();
		u_partner.holdCycles = 0;
		q[3].prio = 2'h1;
		expect_got(q);
	endtask

	task automatic switch_retry();
		ppo_pkt_t q[$];
		switchMode <= 1'b1;
		do_reset();
		q = {mk(2'h0, 2'h0, 4'h2, 8'h04, 32'h2), mk(2'h2, 2'h3, 4'h2, 8'h04, 32'h3),
			mk(2'h2, 2'h0, 4'h8, 8'h04, 32'h4), mk(2'h2, 2'h0, 4'h8, 8'h04, 32'h6)};
		u_partner.holdCycles = 20;
		u_partner.retryLeft  = 1;
		foreach (q[i]) offer(q[i], 1'b1);
		expect_got({q[1], q[2], q[3], q[0]});
	endtask

	// ========================================================================
	// clock, sequence and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial begin
		reset      = 1'b1;
		switchMode = 1'b0;
		tpTxValid  = 1'b0;
		tpTxPkt    = '0;
		lnkRxValid = 1'b0;
		lnkRxPkt   = '0;
		tpRxReady  = 1'b0;
		do_reset();
		tx_order();
		promote();
		tx_full();
		switch_retry();
		give_verdict();
	end

	// about 60 times the expected run length
	initial begin
		#(50 * 20000);
		failures++;
		give_verdict();
	end
endmodule
